// ---- flash_ctl_pkg.sv ----
// Purpose: Shared constants for the flash program/erase host controller
// Assumes: 100 MHz ref_clk, APB slave with 32-bit data
// Notes:   Command codes and status bit positions of the flash device
`default_nettype none
package flash_ctl_pkg;
  // ----------------------------------------
  // Flash command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROG_SETUP   = 8'h40;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONF   = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND      = 8'hB0;
  localparam logic [7:0] CMD_RESUME       = 8'hD0;
  // ----------------------------------------
  // Flash status bit positions
  // ----------------------------------------
  localparam int READY_BIT      = 7;
  localparam int ERASE_FAIL_BIT = 5;
  localparam int PROG_FAIL_BIT  = 4;
  localparam int SUPPLY_LOW_BIT = 3;
  // ----------------------------------------
  // APB register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_DATA   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_RDATA  = 8'h10;
  // CTRL operation codes written by software
  localparam logic [2:0] OP_NONE    = 3'h0;
  localparam logic [2:0] OP_PROGRAM = 3'h1;
  localparam logic [2:0] OP_ERASE   = 3'h2;
  localparam logic [2:0] OP_SUSPEND = 3'h3;
  localparam logic [2:0] OP_RESUME  = 3'h4;
  localparam logic [2:0] OP_CLEAR   = 3'h5;
  localparam logic [2:0] OP_RDARRAY = 3'h6;
  localparam logic [2:0] OP_RDSTAT  = 3'h7;
  // ----------------------------------------
  // Strobe timing
  // ----------------------------------------
  localparam int STROBE_NS     = 70;
  localparam int CLK_NS        = 10;
  localparam int STROBE_CYCLES = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_NS      = 20;
  localparam int SETUP_CYCLES  = (SETUP_NS + CLK_NS - 1) / CLK_NS;
endpackage : flash_ctl_pkg
`default_nettype wire

// ---- flash_bus_cycle.sv ----
// Purpose: One asynchronous strobe cycle (write or read) on the flash pins
// Assumes: Inputs synchronous to ref_clk; data read at end of strobe
// Notes:   Each cycle drops ce_n and we_n/oe_n together and raises both
`default_nettype none
module flash_bus_cycle
  import flash_ctl_pkg::*;
#(
  parameter int AW = 19,
  parameter int DW = 16
) (
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic          start,
  input  wire logic          write,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output var  logic          done,
  output var  logic [DW-1:0] rdata,
  output var  logic [AW-1:0] fl_addr,
  output var  logic          fl_ce_n,
  output var  logic          fl_we_n,
  output var  logic          fl_oe_n,
  output var  logic [DW-1:0] fl_dq_out,
  output var  logic          fl_dq_oe,
  input  wire logic [DW-1:0] fl_dq_in
);
  typedef enum logic [1:0] {
    BC_IDLE   = 2'b00,
    BC_SETUP  = 2'b01,
    BC_STROBE = 2'b10,
    BC_HOLD   = 2'b11
  } bc_state_type;

  bc_state_type state_ff;
  logic [7:0]   cnt_ff;
  logic         wr_ff;

  wire cnt_zero = (cnt_ff == 8'h00);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff  <= BC_IDLE;
      cnt_ff    <= 8'h00;
      wr_ff     <= 1'b0;
      done      <= 1'b0;
      rdata     <= '0;
      fl_addr   <= '0;
      fl_ce_n   <= 1'b1;
      fl_we_n   <= 1'b1;
      fl_oe_n   <= 1'b1;
      fl_dq_out <= '0;
      fl_dq_oe  <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_ff)
        BC_IDLE: begin
          if (start) begin
            fl_addr   <= addr;
            fl_dq_out <= wdata;
            fl_dq_oe  <= write;
            wr_ff     <= write;
            cnt_ff    <= 8'(SETUP_CYCLES);
            state_ff  <= BC_SETUP;
          end
        end
        BC_SETUP: begin
          if (cnt_zero) begin
            // Strobe pair low together; write captured when the strobe rises
            fl_ce_n  <= 1'b0;
            fl_we_n  <= !wr_ff;
            fl_oe_n  <= wr_ff;
            cnt_ff   <= 8'(STROBE_CYCLES);
            state_ff <= BC_STROBE;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        BC_STROBE: begin
          if (cnt_zero) begin
            // Every read toggles ce_n/oe_n so status is refreshed
            rdata    <= fl_dq_in;
            fl_ce_n  <= 1'b1;
            fl_we_n  <= 1'b1;
            fl_oe_n  <= 1'b1;
            cnt_ff   <= 8'(SETUP_CYCLES);
            state_ff <= BC_HOLD;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        BC_HOLD: begin
          // Data held past the rising strobe for the device's decode
          if (cnt_zero) begin
            fl_dq_oe <= 1'b0;
            done     <= 1'b1;
            state_ff <= BC_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        default: state_ff <= BC_IDLE;
      endcase
    end
  end
endmodule : flash_bus_cycle
`default_nettype wire

// ---- flash_program_erase_control.sv ----
// Purpose: Host-side sequencer driving a flash device's program/erase commands
// Assumes: APB slave for software; flash pins synchronous to ref_clk
// Notes:   Software starts one operation; controller polls status to finish
`default_nettype none
// Summary of operation
// - Program: setup command, then address/data write
// - Poll by toggling strobes each status read
// - Issue read command before reading after operation
// - Erase: 20H then D0H inside block
// - Supply-low blocks erases until cleared
// - Suspend pauses; read status to confirm (OP_SUSPEND is refused while busy, so no running erase is suspended)
// - FFH returns to read-array mode
// - Clear status after each operation (not done automatically; flags accumulate until software issues OP_CLEAR)
// - Sticky flags cleared only by clear-status
module flash_program_erase_control
  import flash_ctl_pkg::*;
#(
  parameter int AW = 19,
  parameter int DW = 16
) (
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output var  logic [31:0]   prdata,
  output var  logic          pready,
  output var  logic          pslverr,
  output var  logic [AW-1:0] fl_addr,
  output var  logic          fl_ce_n,
  output var  logic          fl_we_n,
  output var  logic          fl_oe_n,
  output var  logic [DW-1:0] fl_dq_out,
  output var  logic          fl_dq_oe,
  input  wire logic [DW-1:0] fl_dq_in,
  output var  logic          powerdown_reset_n
);
  typedef enum logic [3:0] {
    S_IDLE     = 4'b0000,
    S_CMD1     = 4'b0001,
    S_CMD2     = 4'b0010,
    S_POLL     = 4'b0011,
    S_POLLWAIT = 4'b0100,
    S_CHECK    = 4'b0101,
    S_CLEAR    = 4'b0110,
    S_SINGLE   = 4'b0111,
    S_WAIT     = 4'b1000
  } seq_state_type;

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  seq_state_type   state_ff;
  seq_state_type   ret_ff;
  logic [2:0]      op_ff;
  logic [AW-1:0]   addr_ff;
  logic [DW-1:0]   data_ff;
  logic [7:0]      fstat_ff;
  logic [DW-1:0]   rd_ff;
  logic            busy_ff;
  logic            suspended_ff;
  logic            seq_err_ff;
  logic            bc_start_ff;
  logic            bc_write_ff;
  logic [AW-1:0]   bc_addr_ff;
  logic [DW-1:0]   bc_wdata_ff;
  logic            bc_done;
  logic [DW-1:0]   bc_rdata;

  // --------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------
  wire apb_acc    = psel && penable;
  wire apb_wr     = apb_acc && pwrite;
  wire sel_ctrl   = (paddr == OFS_CTRL);
  wire sel_addr   = (paddr == OFS_ADDR);
  wire sel_data   = (paddr == OFS_DATA);
  wire sel_status = (paddr == OFS_STATUS);
  wire sel_rdata  = (paddr == OFS_RDATA);
  wire mapped     = sel_ctrl | sel_addr | sel_data | sel_status | sel_rdata;
  // A new op is refused while busy; seen as pslverr
  wire start_op   = apb_wr && sel_ctrl && !busy_ff && (pwdata[2:0] != OP_NONE);
  wire wr_refused = apb_wr && sel_ctrl && busy_ff;

  // Busy at bit 8, suspended at 9, sequence error at 10
  wire [31:0] status_word = {21'h00_0000, seq_err_ff, suspended_ff, busy_ff, fstat_ff};
  wire [31:0] rd_mux = sel_ctrl   ? {29'h0000_0000, op_ff} :
                       sel_addr   ? 32'(addr_ff) :
                       sel_data   ? 32'(data_ff) :
                       sel_status ? status_word :
                       sel_rdata  ? 32'(rd_ff) : 32'h0000_0000;

  wire ready_bit = bc_rdata[READY_BIT];
  wire prog_f    = bc_rdata[PROG_FAIL_BIT];
  wire erase_f   = bc_rdata[ERASE_FAIL_BIT];
  wire seq_err   = prog_f && erase_f;

  // First command byte of each operation
  wire [7:0] first_cmd = (op_ff == OP_PROGRAM) ? CMD_PROG_SETUP :
                         (op_ff == OP_ERASE)   ? CMD_ERASE_SETUP :
                         (op_ff == OP_SUSPEND) ? CMD_SUSPEND :
                         (op_ff == OP_RESUME)  ? CMD_RESUME :
                         (op_ff == OP_CLEAR)   ? CMD_CLEAR_STATUS :
                         (op_ff == OP_RDARRAY) ? CMD_READ_ARRAY : CMD_READ_STATUS;
  wire two_step  = (op_ff == OP_PROGRAM) || (op_ff == OP_ERASE);
  wire polls     = two_step || (op_ff == OP_SUSPEND) || (op_ff == OP_RESUME);
  // Second write: data for program, confirm for erase
  wire [DW-1:0] second_data = (op_ff == OP_PROGRAM) ? data_ff : DW'(CMD_ERASE_CONF);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_acc && !pready;
      pslverr <= apb_acc && !pready && (!mapped || wr_refused);
      prdata  <= rd_mux;
    end
  end

  // --------------------------------------------------------------
  // Software-written operand registers
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      addr_ff <= '0;
      data_ff <= '0;
      op_ff   <= OP_NONE;
      powerdown_reset_n <= 1'b0;
    end else begin
      powerdown_reset_n <= 1'b1;
      if (apb_wr && !pready && sel_addr && !busy_ff) addr_ff <= pwdata[AW-1:0];
      if (apb_wr && !pready && sel_data && !busy_ff) data_ff <= pwdata[DW-1:0];
      if (start_op && !pready) op_ff <= pwdata[2:0];
    end
  end

  // --------------------------------------------------------------
  // Operation sequencer
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff     <= S_IDLE;
      ret_ff       <= S_IDLE;
      busy_ff      <= 1'b0;
      suspended_ff <= 1'b0;
      seq_err_ff   <= 1'b0;
      fstat_ff     <= 8'h00;
      rd_ff        <= '0;
      bc_start_ff  <= 1'b0;
      bc_write_ff  <= 1'b0;
      bc_addr_ff   <= '0;
      bc_wdata_ff  <= '0;
    end else begin
      bc_start_ff <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          if (start_op && !pready) begin
            busy_ff  <= 1'b1;
            state_ff <= S_CMD1;
          end
        end
        S_CMD1: begin
          // Setup command at the target address
          bc_start_ff <= 1'b1;
          bc_write_ff <= 1'b1;
          bc_addr_ff  <= addr_ff;
          bc_wdata_ff <= DW'(first_cmd);
          ret_ff      <= two_step ? S_CMD2 : (polls ? S_POLL : S_SINGLE);
          state_ff    <= S_WAIT;
        end
        S_CMD2: begin
          // Address with data or confirm; block bits latched here
          bc_start_ff <= 1'b1;
          bc_write_ff <= 1'b1;
          bc_addr_ff  <= addr_ff;
          bc_wdata_ff <= second_data;
          ret_ff      <= S_POLL;
          state_ff    <= S_WAIT;
        end
        S_POLL: begin
          // While busy, only status reads are issued
          bc_start_ff <= 1'b1;
          bc_write_ff <= 1'b0;
          ret_ff      <= S_CHECK;
          state_ff    <= S_WAIT;
        end
        S_CHECK: begin
          // Ready low means busy: keep polling
          if (!ready_bit) begin
            state_ff <= S_POLL;
          end else begin
            // Errors accumulate in the copy until software clears
            fstat_ff     <= fstat_ff | bc_rdata[7:0];
            seq_err_ff   <= seq_err_ff | seq_err;
            suspended_ff <= (op_ff == OP_SUSPEND);
            busy_ff      <= 1'b0;
            state_ff     <= S_IDLE;
          end
        end
        S_SINGLE: begin
          if (op_ff == OP_CLEAR) begin
            // Only clear-status drops sticky copies
            fstat_ff   <= 8'h00;
            seq_err_ff <= 1'b0;
            state_ff   <= S_CLEAR;
          end else if (op_ff == OP_RDARRAY) begin
            // Read-array then one array read
            bc_start_ff <= 1'b1;
            bc_write_ff <= 1'b0;
            ret_ff      <= S_CLEAR;
            state_ff    <= S_WAIT;
          end else begin
            bc_start_ff <= 1'b1;
            bc_write_ff <= 1'b0;
            ret_ff      <= S_CLEAR;
            state_ff    <= S_WAIT;
          end
        end
        S_CLEAR: begin
          if (op_ff != OP_CLEAR) rd_ff <= bc_rdata;
          busy_ff  <= 1'b0;
          state_ff <= S_IDLE;
        end
        S_WAIT: begin
          if (bc_done) state_ff <= ret_ff;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  flash_bus_cycle #(.AW(AW), .DW(DW)) u_cycle (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .start     (bc_start_ff),
    .write     (bc_write_ff),
    .addr      (bc_addr_ff),
    .wdata     (bc_wdata_ff),
    .done      (bc_done),
    .rdata     (bc_rdata),
    .fl_addr   (fl_addr),
    .fl_ce_n   (fl_ce_n),
    .fl_we_n   (fl_we_n),
    .fl_oe_n   (fl_oe_n),
    .fl_dq_out (fl_dq_out),
    .fl_dq_oe  (fl_dq_oe),
    .fl_dq_in  (fl_dq_in)
  );
endmodule : flash_program_erase_control
`default_nettype wire

// ---- flash_pec_checker.sv ----
// Purpose: Port-level checks of the flash host controller
// Assumes: One clock ref_clk, rst_n synchronous active low
// Notes:   Bound to every instance of the controller
`default_nettype none
module flash_pec_checker
  import flash_ctl_pkg::*;
#(
  parameter int AW = 19,
  parameter int DW = 16
) (
  input wire logic          ref_clk,
  input wire logic          rst_n,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic [AW-1:0] fl_addr,
  input wire logic          fl_ce_n,
  input wire logic          fl_we_n,
  input wire logic          fl_oe_n,
  input wire logic [DW-1:0] fl_dq_out,
  input wire logic          fl_dq_oe,
  input wire logic          powerdown_reset_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_reset_idle: assert property (disable iff (1'b0) !rst_n |=>
    fl_ce_n && fl_we_n && fl_oe_n && !fl_dq_oe && !pready) else $error("not idle in reset");
  a_pd_reset: assert property (disable iff (1'b0) !rst_n |=> !powerdown_reset_n)
    else $error("device reset not held");
  a_pd_follow: assert property ($past(rst_n) |-> powerdown_reset_n)
    else $error("device reset not released");
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_err_qual: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_write_strb: assert property ($fell(fl_we_n) |-> !fl_ce_n && fl_oe_n && fl_dq_oe)
    else $error("bad write strobe");
  a_strobe_len: assert property ($fell(fl_ce_n) |-> (!fl_ce_n)[*7] ##[1:2] fl_ce_n)
    else $error("bad strobe length");
  a_write_hold: assert property (!fl_we_n && !$past(fl_we_n) |->
    $stable(fl_dq_out) && $stable(fl_addr) && fl_dq_oe) else $error("write data moved");
  a_read_oe: assert property ($fell(fl_oe_n) |-> !fl_ce_n && fl_we_n && !fl_dq_oe)
    else $error("bad read strobe");
  c_write: cover property ($fell(fl_we_n));
  c_read: cover property ($fell(fl_oe_n));
  c_error: cover property (pslverr);
endmodule : flash_pec_checker
bind flash_program_erase_control flash_pec_checker #(.AW(AW), .DW(DW)) flash_pec_checker_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
  .fl_oe_n(fl_oe_n), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe),
  .powerdown_reset_n(powerdown_reset_n));
`default_nettype wire

// ---- flash_dev_model.sv ----
// Purpose: Behavioural flash device for the controller bench
// Assumes: Strobes move on ref_clk edges
// Notes:   Tiny array: 8 words in each of two blocks
`default_nettype none
module flash_dev_model #(
  parameter int BUSY_CYC = 20
) (
  input  wire logic        clk,
  input  wire logic        pd_n,
  input  wire logic [18:0] a,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [15:0] dq,
  input  wire logic        vpp_ok,
  input  wire logic        fail,
  output var  logic [15:0] q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [16];
  logic [15:0] lastq = 16'h5A5A;
  logic [6:0]  sr;
  logic [1:0]  pend;
  logic        st_mode, ers, susp, pwe, pce;
  int          busy = 0;
  wire         rdy    = busy == 0 || susp;
  wire [3:0]   ix     = {a[12], a[2:0]};
  wire         wr_end = !pwe && !pce && (we_n || ce_n);
  // Released bus shows the inverse, so a stale sample never looks right
  assign q = (!ce_n && !oe_n) ? (st_mode ? {8'h00, rdy, sr} : mem[ix]) : ~lastq;
  initial for (int i = 0; i < 16; i++) mem[i] = 16'hFFFF;
  always @(posedge clk) begin
    pwe <= we_n;
    pce <= ce_n;
    if (!ce_n && !oe_n) lastq <= q;
    if (!rdy) busy <= busy - 1;
    if (!pd_n) begin
      sr <= '0;
      st_mode <= 1'b0;
      pend <= 2'd0;
      busy <= 0;
      susp <= 1'b0;
    end else if (wr_end && !rdy) begin
      if (dq[7:0] == 8'h70) st_mode <= 1'b1;
      if (dq[7:0] == 8'hB0 && ers) susp <= 1'b1;
    end else if (wr_end && susp) begin
      if (dq[7:0] == 8'hFF) st_mode <= 1'b0;
      if (dq[7:0] == 8'h70 || dq[7:0] == 8'hD0) st_mode <= 1'b1;
      if (dq[7:0] == 8'hD0) susp <= 1'b0;
    end else if (wr_end && pend == 2'd1) begin
      pend <= 2'd0;
      st_mode <= 1'b1;
      ers <= 1'b0;
      busy <= vpp_ok ? BUSY_CYC : 0;
      if (!vpp_ok) sr[3] <= 1'b1;
      else if (fail) sr[4] <= 1'b1;
      else mem[ix] <= mem[ix] & dq;
    end else if (wr_end && pend == 2'd2) begin
      pend <= 2'd0;
      st_mode <= 1'b1;
      ers <= 1'b1;
      if (dq[7:0] != 8'hD0) sr[5:4] <= 2'b11;
      else if (!vpp_ok) {sr[5], sr[3]} <= 2'b11;
      else if (sr[3]) sr[5] <= 1'b1;
      else begin
        busy <= BUSY_CYC;
        if (fail) sr[5] <= 1'b1;
        else for (int i = 0; i < 16; i++) if (i[3] == a[12]) mem[i] <= 16'hFFFF;
      end
    end else if (wr_end) begin
      case (dq[7:0])
        8'h40: pend <= 2'd1;
        8'h20: pend <= 2'd2;
        8'h70: st_mode <= 1'b1;
        8'hFF: st_mode <= 1'b0;
        8'h50: sr <= '0;
        default: sr[5:4] <= 2'b11;
      endcase
    end
  end
endmodule : flash_dev_model
`default_nettype wire

// ---- flash_program_erase_control_tb.sv ----
// Purpose: Self-checking bench of the flash host controller
// Assumes: APB master tasks, behavioural flash model
// Notes:   Status words compared whole, busy and upper bits included
`default_nettype none
module flash_program_erase_control_tb
  import flash_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic        vpp_ok  = 1'b1;
  logic        fail    = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, fl_ce_n, fl_we_n, fl_oe_n, fl_dq_oe, pd_n;
  logic [18:0] fl_addr;
  logic [15:0] fl_dq_out, q, dq;
  int          err_count = 0, n_compared = 0, cyc = 0;
  assign dq = fl_dq_oe ? fl_dq_out : q;
  always #5 ref_clk = ~ref_clk;
  flash_program_erase_control flash_program_erase_control_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n),
    .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_dq_in(dq), .powerdown_reset_n(pd_n));
  flash_dev_model flash_dev_model_i (.clk(ref_clk), .pd_n(pd_n), .a(fl_addr), .ce_n(fl_ce_n),
    .we_n(fl_we_n), .oe_n(fl_oe_n), .dq(dq), .vpp_ok(vpp_ok), .fail(fail), .q(q));
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  // Ceiling well above the 1200 or so cycles the tests need
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_idle;
    int i;
    i = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      i++;
    end while (rd[8] !== 1'b0 && i < 100);
  endtask : wait_idle
  task op(input logic [2:0] o);
    apb(1'b1, OFS_CTRL, {29'h0, o});
    wait_idle();
  endtask : op
  task prog(input logic [31:0] ad, input logic [31:0] d);
    apb(1'b1, OFS_ADDR, ad);
    apb(1'b1, OFS_DATA, d);
    op(OP_PROGRAM);
  endtask : prog
  task arr(input logic [31:0] ad);
    apb(1'b1, OFS_ADDR, ad);
    op(OP_RDARRAY);
    apb(1'b0, OFS_RDATA, 32'h0000_0000);
  endtask : arr
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b0, 8'h14, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    check(rd, 32'h0000_0000);
    $display("test unmapped done");
    prog(32'h0000_0003, 32'h0000_F0F0);
    check(rd, 32'h0000_0080);
    prog(32'h0000_0003, 32'h0000_FF0F);
    arr(32'h0000_0003);
    check(rd, 32'h0000_F000);
    $display("test program done");
    prog(32'h0000_1003, 32'h0000_00AA);
    apb(1'b1, OFS_ADDR, 32'h0000_0003);
    apb(1'b1, OFS_CTRL, {29'h0, OP_ERASE});
    apb(1'b1, OFS_CTRL, {29'h0, OP_PROGRAM});
    check({31'h0, err}, 32'h0000_0001);
    wait_idle();
    check(rd, 32'h0000_0080);
    arr(32'h0000_0003);
    check(rd, 32'h0000_FFFF);
    arr(32'h0000_1003);
    check(rd, 32'h0000_00AA);
    $display("test erase done");
    fail <= 1'b1;
    prog(32'h0000_0003, 32'h0000_0000);
    check(rd, 32'h0000_0090);
    op(OP_ERASE);
    check(rd, 32'h0000_04B0);
    fail <= 1'b0;
    op(OP_ERASE);
    check(rd, 32'h0000_04B0);
    op(OP_CLEAR);
    prog(32'h0000_0003, 32'h0000_1234);
    check(rd, 32'h0000_0080);
    $display("test faults done");
    vpp_ok <= 1'b0;
    op(OP_PROGRAM);
    check(rd, 32'h0000_0088);
    op(OP_CLEAR);
    op(OP_ERASE);
    check(rd, 32'h0000_00A8);
    vpp_ok <= 1'b1;
    op(OP_ERASE);
    check(rd, 32'h0000_00A8);
    arr(32'h0000_0003);
    check(rd, 32'h0000_1234);
    op(OP_RDSTAT);
    apb(1'b0, OFS_RDATA, 32'h0000_0000);
    check(rd, 32'h0000_00A8);
    $display("test supply done");
    test_done();
  end
endmodule : flash_program_erase_control_tb
`default_nettype wire
